//--- hw/wtd_top.sv
// Wake-up timer sequencer with peripheral clock ratio register
`timescale 1ns/10ps
`include "wtd_cfg.svh"
module wtd_top (
  // Clock, reset, enable
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            ce,
  // Reset sources
  input  wire logic            ext_rst_n,
  input  wire logic            wdt_rst,
  // Oscillator
  input  wire logic            osc_tick,
  output logic                 osc_en_q,
  // On-chip initialisation
  output logic                 init_en_q,
  input  wire logic            init_done,
  // Power-down and wake
  input  wire logic            pd_req,
  input  wtd_pkg::wtd_wake_type wake,
  input  wire logic            rtc_own_osc,
  output logic [3:0]           irq_q,
  output logic                 cpu_run_q,
  // Register port
  input  wtd_pkg::wtd_reg_wr_type reg_wr,
  output logic [7:0]           reg_rdata_q,
  // Peripheral clock enable
  output logic                 pclk_en_q
);
  import wtd_pkg::*;

  wtd_state_type state_q;
  wtd_state_type state_d;
  logic [12:0]   cnt_q;
  logic [3:0]    src_q;
  logic [1:0]    ratio_q;
  logic          ext_prev_q;
  logic          rst_evt;
  logic          rtc_hit;
  logic          wake_hit;
  logic          cnt_done;
  logic          ratio_wr;

  // Reset events: watchdog pulse or a falling external reset
  assign rst_evt  = wdt_rst | (ext_prev_q & ~ext_rst_n);
  // RTC wakes only when clocked from its own pins
  assign rtc_hit  = wake.rtc & rtc_own_osc;
  // Pin and mode setup is software's job before power-down
  assign wake_hit = (|wake.eint) | rtc_hit;
  assign cnt_done = (state_q == ST_COUNT) && osc_tick &&
                    (cnt_q == `WTD_WAKE_LAST);
  // Reserved select code is dropped at the write
  assign ratio_wr = reg_wr.wr &&
                    wtd_sel_ok(reg_wr.data[`WTD_SEL_MSB:`WTD_SEL_LSB]);

  // Sequencer next state; any reset event restarts the count
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (wake_hit) begin
          state_d = ST_WAIT_OSC;
        end
      end
      ST_WAIT_OSC: begin
        if (osc_tick) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (cnt_done) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_done) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (ext_rst_n) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pd_req) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_WAIT_OSC;
      end
    endcase
    if (rst_evt) begin
      state_d = ST_WAIT_OSC;
    end
  end

  // State and sequencer outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q    <= ST_WAIT_OSC;
      osc_en_q   <= 1'b1;
      init_en_q  <= 1'b0;
      cpu_run_q  <= 1'b0;
      ext_prev_q <= 1'b1;
    end else if (ce) begin
      state_q    <= state_d;
      osc_en_q   <= (state_d != ST_OFF);
      init_en_q  <= (state_d == ST_INIT);
      cpu_run_q  <= (state_d == ST_RUN);
      ext_prev_q <= ext_rst_n;
    end
  end

  // Oscillator clock counter, held clear outside the count state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 13'h0000;
    end else if (ce) begin
      if (state_q != ST_COUNT || rst_evt) begin
        cnt_q <= 13'h0000;
      end else if (osc_tick) begin
        cnt_q <= cnt_q + 13'h0001;
      end
    end
  end

  // Wake sources are held until the count expires, then passed on
  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_q <= 4'h0;
      irq_q <= 4'h0;
    end else if (ce) begin
      irq_q <= (cnt_done && !rst_evt) ? src_q : 4'h0;
      if (rst_evt || cnt_done) begin
        src_q <= 4'h0;
      end else if (state_q == ST_OFF && wake_hit) begin
        src_q <= {rtc_hit, wake.eint};
      end
    end
  end

  // Ratio register; every reset brings back quarter rate
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ratio_q     <= `WTD_RATIO_RESET;
      reg_rdata_q <= 8'h00;
    end else if (ce) begin
      if (rst_evt) begin
        ratio_q <= `WTD_RATIO_RESET;
      end else if (ratio_wr) begin
        ratio_q <= reg_wr.data[`WTD_SEL_MSB:`WTD_SEL_LSB];
      end
      // Reserved bits read as zero, never stored
      reg_rdata_q <= {6'h00, ratio_q};
    end
  end

  // Enable generator; it waits for a period end before switching
  wtd_clkdiv u_div (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .div_rst   (rst_evt),
    .sel       (ratio_q),
    .pclk_en_q (pclk_en_q)
  );

  // Last counted tick leads straight into init
  property p_count;
    @(posedge clk) disable iff (!resetn)
      (ce && cnt_done && !rst_evt) |=> init_en_q && state_q == ST_INIT;
  endproperty
  a_count: assert property (p_count)
    else $error("init not started after wake count");

  // Processor released only from hold with reset high
  property p_run;
    @(posedge clk) disable iff (!resetn)
      $rose(cpu_run_q) |-> $past(state_q) == ST_HOLD && $past(ext_rst_n);
  endproperty
  a_run: assert property (p_run)
    else $error("processor released too early");

  // Reset event always restarts the sequence
  property p_rst;
    @(posedge clk) disable iff (!resetn)
      (ce && rst_evt) |=> state_q == ST_WAIT_OSC && !cpu_run_q && osc_en_q;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset did not restart wake sequence");

  // Power-down stops the oscillator
  property p_pd;
    @(posedge clk) disable iff (!resetn)
      (ce && state_q == ST_RUN && pd_req && !rst_evt)
        |=> !osc_en_q && state_q == ST_OFF;
  endproperty
  a_pd: assert property (p_pd)
    else $error("oscillator not stopped in power-down");

  // RTC on a foreign clock must not wake
  property p_rtc;
    @(posedge clk) disable iff (!resetn)
      (ce && state_q == ST_OFF && !rtc_own_osc && wake.eint == 3'h0 &&
       !rst_evt) |=> state_q == ST_OFF;
  endproperty
  a_rtc: assert property (p_rtc)
    else $error("woke without an enabled source");

  // Interrupts only leave at count expiry
  property p_irq;
    @(posedge clk) disable iff (!resetn)
      (irq_q != 4'h0) |-> $past(state_q) == ST_COUNT &&
                          state_q == ST_INIT;
  endproperty
  a_irq: assert property (p_irq)
    else $error("wake interrupt delivered before expiry");

  // Reserved select write leaves the ratio unchanged
  property p_ign;
    @(posedge clk) disable iff (!resetn)
      (ce && reg_wr.wr && reg_wr.data[1:0] == `WTD_SEL_RSVD && !rst_evt)
        |=> ratio_q == $past(ratio_q);
  endproperty
  a_ign: assert property (p_ign)
    else $error("reserved select value was stored");

  // Quarter rate after reset, reserved bits read zero
  property p_rst_ratio;
    @(posedge clk)
      !resetn |=> ratio_q == `WTD_SEL_QUARTER ##1 reg_rdata_q == 8'h00;
  endproperty
  a_rst_ratio: assert property (p_rst_ratio)
    else $error("ratio not quarter after reset");
endmodule

//--- hw/wtd_cfg.svh
// Constants of the wake-up timer and peripheral clock divider
`ifndef WTD_CFG_SVH
`define WTD_CFG_SVH

// Divider register location and layout
`define WTD_RATIO_OFFSET 32'hE01FC100
`define WTD_SEL_LSB      0
`define WTD_SEL_MSB      1
`define WTD_RATIO_RESET  2'h0

// Divider select encodings
`define WTD_SEL_QUARTER  2'h0
`define WTD_SEL_EQUAL    2'h1
`define WTD_SEL_HALF     2'h2
`define WTD_SEL_RSVD     2'h3

// Wake-up count in oscillator clocks
`define WTD_WAKE_COUNT   13'h1000
`define WTD_WAKE_LAST    13'h0FFF

`endif

//--- hw/wtd_pkg.sv
// Types and helper functions of the wake-up timer block
package wtd_pkg;
`include "wtd_cfg.svh"

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_OFF      = 6'h01,
    ST_WAIT_OSC = 6'h02,
    ST_COUNT    = 6'h04,
    ST_INIT     = 6'h08,
    ST_HOLD     = 6'h10,
    ST_RUN      = 6'h20
  } wtd_state_type;

  // Wake requests from the interrupt lines
  typedef struct packed {
    logic       rtc;
    logic [2:0] eint;
  } wtd_wake_type;

  // Register write strobe with data
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } wtd_reg_wr_type;

  // Reserved select code must leave the ratio alone
  function automatic logic wtd_sel_ok(input logic [1:0] sel);
    wtd_sel_ok = (sel != `WTD_SEL_RSVD);
  endfunction

  // Last count of a peripheral clock period for a select code
  function automatic logic [1:0] wtd_last(input logic [1:0] sel);
    case (sel)
      `WTD_SEL_EQUAL: wtd_last = 2'h0;
      `WTD_SEL_HALF:  wtd_last = 2'h1;
      default:        wtd_last = 2'h3;
    endcase
  endfunction
endpackage

//--- hw/wtd_clkdiv.sv
// Peripheral clock enable divider with boundary-aligned ratio changes
`timescale 1ns/10ps
`include "wtd_cfg.svh"
module wtd_clkdiv (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       div_rst,
  // Requested select code
  input  wire logic [1:0] sel,
  // Peripheral clock enable pulse
  output logic            pclk_en_q
);
  import wtd_pkg::*;

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] sel_act_q;
  logic       at_end;

  // End of the running period; new ratio is only picked up here
  assign at_end = (cnt_q == wtd_last(sel_act_q));
  assign cnt_d  = at_end ? 2'h0 : cnt_q + 2'h1;

  // Counter, active ratio and enable pulse
  always_ff @(posedge clk) begin
    if (!resetn || div_rst) begin
      cnt_q     <= 2'h0;
      sel_act_q <= `WTD_SEL_QUARTER;
      pclk_en_q <= 1'b0;
    end else if (ce) begin
      cnt_q     <= cnt_d;
      pclk_en_q <= at_end;
      if (at_end) begin
        sel_act_q <= sel;
      end
    end
  end

  // Half ratio toggles the enable on every enabled cycle
  property p_half;
    @(posedge clk) disable iff (!resetn || div_rst)
      (ce && sel_act_q == `WTD_SEL_HALF) |=> pclk_en_q != $past(pclk_en_q);
  endproperty
  a_half: assert property (p_half)
    else $error("half ratio enable pattern broken");

  // Ratio switches only at a period boundary
  property p_bound;
    @(posedge clk) disable iff (!resetn || div_rst)
      ##1 (sel_act_q != $past(sel_act_q)) |-> $past(at_end) && $past(ce);
  endproperty
  a_bound: assert property (p_bound)
    else $error("ratio changed inside a period");

  // Equal ratio enables every cycle
  property p_equal;
    @(posedge clk) disable iff (!resetn || div_rst)
      (ce && sel_act_q == `WTD_SEL_EQUAL && sel == `WTD_SEL_EQUAL)
        [*2] |-> ##1 pclk_en_q;
  endproperty
  a_equal: assert property (p_equal)
    else $error("equal ratio did not enable every cycle");
endmodule

//--- dv/wtd_osc_model.sv
// Crystal oscillator model feeding one tick per oscillator clock
`timescale 1ns/10ps
module wtd_osc_model (
  // Clock
  input  wire logic clk,
  // Enable from the device, start-up gate, slow crystal select
  input  wire logic osc_en_q,
  input  wire logic run,
  input  wire logic slow,
  // Oscillator tick
  output logic      osc_tick
);
  logic [1:0] div_q;

  // Silent while disabled or still starting; slow ticks every third cycle
  always @(posedge clk) begin
    if (!(run && osc_en_q)) begin
      osc_tick <= 1'b0;
      div_q    <= 2'h0;
    end else begin
      osc_tick <= (div_q == 2'h0);
      div_q    <= (slow && div_q != 2'h2) ? div_q + 2'h1 : 2'h0;
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench of the wake-up sequencer and clock ratio register
`timescale 1ns/10ps
module testbench;
  import wtd_pkg::*;
  logic           clk, resetn, ce, ext_rst_n, wdt_rst, init_done, pd_req;
  logic           rtc_own_osc, run, slow, osc_tick, osc_en_q, init_en_q;
  logic           cpu_run_q, pclk_en_q;
  logic [3:0]     irq_q, irq_seen;
  logic [7:0]     reg_rdata_q, d;
  logic [1:0]     sel;
  logic [31:0]    seed;
  wtd_wake_type   wake;
  wtd_reg_wr_type reg_wr;
  int             errors, comparisons, ticks, irq_n, k, p;

  wtd_top dut_u (.clk(clk), .resetn(resetn), .ce(ce),
    .ext_rst_n(ext_rst_n), .wdt_rst(wdt_rst), .osc_tick(osc_tick),
    .osc_en_q(osc_en_q), .init_en_q(init_en_q), .init_done(init_done),
    .pd_req(pd_req), .wake(wake), .rtc_own_osc(rtc_own_osc),
    .irq_q(irq_q), .cpu_run_q(cpu_run_q), .reg_wr(reg_wr),
    .reg_rdata_q(reg_rdata_q), .pclk_en_q(pclk_en_q));
  wtd_osc_model osc_u (.clk(clk), .osc_en_q(osc_en_q), .run(run),
    .slow(slow), .osc_tick(osc_tick));

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Ticks and wake interrupts as the device samples them
  always @(posedge clk) begin
    if (osc_tick) ticks++;
    if (irq_q != 4'h0) begin
      irq_n++;
      irq_seen = irq_q;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int period(input logic [1:0] s);
    return (s == 2'h1) ? 1 : (s == 2'h2) ? 2 : 4;
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return init_en_q;
      1: return cpu_run_q;
      2: return pclk_en_q;
      default: return osc_en_q;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait; a hang counts as a mismatch
  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    while (pick(w) !== v) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        check(16'h0, 16'h1);
        end_sim();
      end
    end
  endtask

  // Skip the boundary pulse, then time one full period
  task automatic measure();
    wait_for(2, 1'b1);
    @(negedge clk);
    wait_for(2, 1'b1);
    @(negedge clk);
    p = 1;
    while (pclk_en_q !== 1'b1 && p < 9) begin
      @(negedge clk);
      p++;
    end
  endtask

  task automatic boot();
    wait_for(0, 1'b1);
    check(16'(ticks), 16'h1001);
    check(cpu_run_q, 1'b0);
    init_done = 1'b1;
    wait_for(0, 1'b0);
    init_done = 1'b0;
    repeat (4) begin
      @(negedge clk);
      check(cpu_run_q, ext_rst_n);
    end
    ext_rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check(cpu_run_q, 1'b1);
  endtask

  // Chip reset from the pin or the watchdog restarts the count
  task automatic restart(input logic wd);
    run = 1'b0;
    wdt_rst = wd;
    ext_rst_n = wd;
    @(negedge clk);
    wdt_rst = 1'b0;
    ticks = 0;
    repeat (5) @(negedge clk);
    check({cpu_run_q, reg_rdata_q}, 16'h0);
    slow = 1'(rnd());
    run = 1'b1;
    boot();
  endtask

  initial begin
    {ext_rst_n, ce, rtc_own_osc} = 3'h7;
    {resetn, wdt_rst, init_done, pd_req, run, slow} = 6'h00;
    wake = '0;
    reg_wr = '0;
    seed = 32'h066F2CC4;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check(reg_rdata_q, 8'h00);
    measure();
    check(16'(p), 16'd4);
    ticks = 0;
    run = 1'b1;
    boot();
    // Corner codes first, then random codes; reserved bits written as zero
    sel = 2'h0;
    for (k = 0; k < 9; k++) begin
      d = (k == 0) ? 8'h02 : (k == 1) ? 8'h03 : (k == 2) ? 8'h01 :
          (k == 3) ? 8'h00 : {6'h00, 2'(rnd())};
      if (d[1:0] != 2'h3) sel = d[1:0];
      reg_wr = {1'b1, d};
      @(negedge clk);
      reg_wr = '0;
      @(negedge clk);
      check(reg_rdata_q, {6'h00, sel});
      measure();
      check(16'(p), 16'(period(sel)));
    end
    // Frozen clock enable: neither the strobe nor power-down is taken
    ce = 1'b0;
    pd_req = 1'b1;
    reg_wr = {1'b1, 6'h00, (sel == 2'h1) ? 2'h0 : 2'h1};
    repeat (6) @(negedge clk);
    {ce, pd_req} = 2'h2;
    reg_wr = '0;
    check({cpu_run_q, reg_rdata_q}, {1'b1, 6'h00, sel});
    restart(1'b0);
    restart(1'b1);
    // Wake lines pulsed after power-down, one source each pass
    for (k = 0; k < 4; k++) begin
      pd_req = 1'b1;
      @(negedge clk);
      pd_req = 1'b0;
      wait_for(3, 1'b0);
      repeat (3) @(negedge clk);
      check(osc_en_q, 1'b0);
      rtc_own_osc = 1'b0;
      wake = 4'h8;
      @(negedge clk);
      wake = 4'h0;
      repeat (4) @(negedge clk);
      check(osc_en_q, 1'b0);
      rtc_own_osc = 1'b1;
      ticks = 0;
      irq_n = 0;
      wake = 4'h1 << k;
      @(negedge clk);
      wake = 4'h0;
      repeat (20) @(negedge clk);
      check(16'(irq_n), 16'h0);
      boot();
      check({irq_n[3:0], irq_seen}, {4'h1, 4'h1 << k});
    end
    end_sim();
  end
endmodule
